/* rtl/aei_pkg.sv */
// shared constants of the alarm and error interrupt block
package aei_pkg;

   // register bus geometry
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;

   // register offsets
   localparam logic [3:0] STATUS_OFS  = 4'h0;
   localparam logic [3:0] ENABLE_OFS  = 4'h1;
   localparam logic [3:0] BLOCK_OFS   = 4'h2;
   localparam logic [3:0] OOF_CFG_OFS = 4'h3;
   localparam logic [3:0] STATE_OFS   = 4'h4;

   // status and enable field positions (same layout in both)
   localparam int YEL_BIT = 0;
   localparam int AIS_BIT = 1;
   localparam int OOF_BIT = 2;
   localparam int LCV_BIT = 3;
   localparam int SRC_W   = 4;

   // block-level enable and live defect state positions
   localparam int BLOCK_ALARM_BIT = 0;
   localparam int STATE_YEL_BIT   = 0;
   localparam int STATE_AIS_BIT   = 1;
   localparam int STATE_OOF_BIT   = 2;

   // framing check configuration fields
   localparam int CNT4_W  = 4;
   localparam int TOL_LSB = 0;
   localparam int WIN_LSB = 4;

   // reset values
   localparam logic [3:0] STATUS_RST = 4'h0;
   localparam logic [3:0] ENABLE_RST = 4'h0;
   localparam logic       BLOCK_RST  = 1'b0;
   localparam logic [3:0] TOL_RST    = 4'h2;
   localparam logic [3:0] WIN_RST    = 4'h4;

   // timing: persistence times in ms, counts derived from the clock
   localparam int NS_PER_MS      = 1000000;
   localparam int CLK_PERIOD_NS  = 20;
   localparam int AIS_PERSIST_MS = 42;
   localparam int YEL_PERSIST_MS = 900;
   localparam int AIS_PERSIST_CYC =
      (AIS_PERSIST_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int YEL_PERSIST_CYC =
      (YEL_PERSIST_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int YEL_CLEAR_CYC = 1;

   // receive framing state
   typedef enum logic [0:0] {
      AEI_IN_FRAME     = 1'b0,
      AEI_OUT_OF_FRAME = 1'b1
   } aei_frame_e;

endpackage

/* rtl/aei_persist.sv */
`timescale 1ns/1ps
// persistence filter: the defect flips only after the raw condition has
// disagreed with it for the given number of consecutive cycles
module aei_persist #(
   parameter int unsigned DECLARE_CYC = 2,
   parameter int unsigned CLEAR_CYC   = 2,
   parameter int unsigned CNT_W       = 32
) (
   input  wire logic mclk,   // system clock
   input  wire logic rst_n,  // synchronous reset, active low
   input  wire logic cond,   // raw condition, same clock domain
   output logic      defect  // filtered defect state, registered
);

   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] target;
   logic             differ;
   logic             done;

   // a glitch in the raw condition restarts the run from zero
   assign target = defect ? CNT_W'(CLEAR_CYC) : CNT_W'(DECLARE_CYC);
   assign differ = cond != defect;
   assign done   = differ && (cnt == target - CNT_W'(1));

   // run counter and defect state
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cnt    <= '0;
         defect <= 1'b0;
      end else if (!differ) begin
         cnt <= '0;
      end else if (done) begin
         cnt    <= '0;
         defect <= ~defect;
      end else begin
         cnt <= cnt + CNT_W'(1);
      end
   end

endmodule

/* rtl/aei_top.sv */
`timescale 1ns/1ps
module aei_top #(
   parameter int unsigned AIS_CYC     = aei_pkg::AIS_PERSIST_CYC,
   parameter int unsigned YEL_CYC     = aei_pkg::YEL_PERSIST_CYC,
   parameter int unsigned PERSIST_W   = 32
) (
   input  wire logic       mclk,                // system clock, 50 MHz
   input  wire logic       rst_n,               // synchronous reset
   input  wire logic [3:0] addr,                // register address
   input  wire logic [7:0] wr_data,             // register write data
   input  wire logic       wr_en,               // write strobe
   input  wire logic       rd_en,               // read strobe
   output logic      [7:0] rd_data,             // read data, next cycle
   input  wire logic       framing_bit_valid,   // a framing bit checked
   input  wire logic       framing_bit_err,     // that framing bit wrong
   input  wire logic       frame_sync_found,    // framer regained sync
   input  wire logic       ais_cond,            // raw all-ones condition
   input  wire logic       remote_alarm_cond,   // raw remote alarm pattern
   input  wire logic       line_code_violation, // one pulse per violation
   output logic            irq,                 // level interrupt request
   output logic            oof_defect,          // out-of-frame state
   output logic            ais_defect,          // filtered AIS state
   output logic            yellow_alarm         // filtered yellow state
);

   localparam int SW = aei_pkg::SRC_W;
   localparam int CW = aei_pkg::CNT4_W;

   // sticky flag update: a new event beats a simultaneous clear
   function automatic logic [SW-1:0] sticky(input logic [SW-1:0] cur,
                                            input logic [SW-1:0] clr,
                                            input logic [SW-1:0] set);
      sticky = (cur & ~clr) | set;
   endfunction

   // widen a narrow field into a byte with zeros above
   function automatic logic [7:0] zext4(input logic [3:0] v);
      zext4 = {4'h0, v};
   endfunction

   // register state
   logic [SW-1:0]          status;
   logic [SW-1:0]          enable;
   logic                   block_en;
   logic [CW-1:0]          tolerance;
   logic [CW-1:0]          window;
   aei_pkg::aei_frame_e    frame_state;
   logic [CW-1:0]          err_cnt;
   logic [CW-1:0]          bit_cnt;
   logic                   oof_prev;
   logic                   ais_prev;
   logic                   yel_prev;

   // next values and decode
   logic [SW-1:0]          next_status;
   logic [SW-1:0]          set_vec;
   logic [SW-1:0]          clr_vec;
   logic [SW-1:0]          wc_vec;
   logic [SW-1:0]          rd_vec;
   logic                   next_irq;
   logic [7:0]             next_rd_data;
   logic                   hit_status;
   logic                   hit_enable;
   logic                   hit_block;
   logic                   hit_cfg;
   logic                   hit_state;
   logic                   err_limit;
   logic                   win_end;
   logic                   oof_declare;
   logic                   oof_clear;
   logic [7:0]             state_byte;
   logic                   next_oof;

   // address decode for the plain register port
   assign hit_status = addr == aei_pkg::STATUS_OFS;
   assign hit_enable = addr == aei_pkg::ENABLE_OFS;
   assign hit_block  = addr == aei_pkg::BLOCK_OFS;
   assign hit_cfg    = addr == aei_pkg::OOF_CFG_OFS;
   assign hit_state  = addr == aei_pkg::STATE_OFS;

   // ------------------------------------------------------------------
   // out-of-frame detection: count errors over a window of framing bits
   // ------------------------------------------------------------------

   // tolerance of zero is treated as one so a stray error still counts
   assign err_limit = framing_bit_valid && framing_bit_err &&
                      (err_cnt + CW'(1) >= tolerance);
   assign win_end   = framing_bit_valid &&
                      (bit_cnt + CW'(1) >= window);
   assign oof_declare = (frame_state == aei_pkg::AEI_IN_FRAME) &&
                        err_limit;
   assign oof_clear   = (frame_state == aei_pkg::AEI_OUT_OF_FRAME) &&
                        frame_sync_found;

   // framing state machine; counters restart at every window boundary
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         frame_state <= aei_pkg::AEI_IN_FRAME;
      end else begin
         case (frame_state)
            aei_pkg::AEI_IN_FRAME: begin
               if (oof_declare) begin
                  frame_state <= aei_pkg::AEI_OUT_OF_FRAME;
               end
            end
            aei_pkg::AEI_OUT_OF_FRAME: begin
               if (oof_clear) begin
                  frame_state <= aei_pkg::AEI_IN_FRAME;
               end
            end
            default: begin
               frame_state <= aei_pkg::AEI_IN_FRAME;
            end
         endcase
      end
   end

   // error and bit counters, only meaningful while in frame
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         err_cnt <= '0;
         bit_cnt <= '0;
      end else if (frame_state != aei_pkg::AEI_IN_FRAME ||
                   oof_declare || win_end) begin
         err_cnt <= '0;
         bit_cnt <= '0;
      end else if (framing_bit_valid) begin
         bit_cnt <= bit_cnt + CW'(1);
         if (framing_bit_err) begin
            err_cnt <= err_cnt + CW'(1);
         end
      end
   end

   // next framing state as a plain bit, so the pin can be a flop and
   // still switch on the same edge as the state machine
   assign next_oof = (frame_state == aei_pkg::AEI_IN_FRAME) ?
                     oof_declare : !oof_clear;

   // out-of-frame pin, registered beside the state it mirrors
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         oof_defect <= 1'b0;
      end else begin
         oof_defect <= next_oof;
      end
   end

   // ------------------------------------------------------------------
   // persistence filters for AIS and remote alarm
   // ------------------------------------------------------------------

   // AIS needs the same dwell time in both directions
   aei_persist #(
      .DECLARE_CYC (AIS_CYC),
      .CLEAR_CYC   (AIS_CYC),
      .CNT_W       (PERSIST_W)
   ) u_ais (
      .mclk   (mclk),
      .rst_n  (rst_n),
      .cond   (ais_cond),
      .defect (ais_defect)
   );

   // yellow drops a cycle after the pattern goes away
   aei_persist #(
      .DECLARE_CYC (YEL_CYC),
      .CLEAR_CYC   (aei_pkg::YEL_CLEAR_CYC),
      .CNT_W       (PERSIST_W)
   ) u_yel (
      .mclk   (mclk),
      .rst_n  (rst_n),
      .cond   (remote_alarm_cond),
      .defect (yellow_alarm)
   );

   // previous defect states, for change detection
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         oof_prev <= 1'b0;
         ais_prev <= 1'b0;
         yel_prev <= 1'b0;
      end else begin
         oof_prev <= oof_defect;
         ais_prev <= ais_defect;
         yel_prev <= yellow_alarm;
      end
   end

   // ------------------------------------------------------------------
   // sticky status flags
   // ------------------------------------------------------------------

   // any edge of a defect state, declare or clear, is a change event
   assign set_vec[aei_pkg::YEL_BIT] = yellow_alarm != yel_prev;
   assign set_vec[aei_pkg::AIS_BIT] = ais_defect != ais_prev;
   assign set_vec[aei_pkg::OOF_BIT] = oof_defect != oof_prev;
   assign set_vec[aei_pkg::LCV_BIT] = line_code_violation;

   // flags clear both on read and by writing ones over them
   assign rd_vec  = (rd_en && hit_status) ? {SW{1'b1}} : '0;
   assign wc_vec  = (wr_en && hit_status) ? wr_data[SW-1:0] : '0;
   assign clr_vec = rd_vec | wc_vec;

   assign next_status = sticky(status, clr_vec, set_vec);

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         status <= aei_pkg::STATUS_RST;
      end else begin
         status <= next_status;
      end
   end

   // ------------------------------------------------------------------
   // writable registers
   // ------------------------------------------------------------------

   // only bits 3..0 are kept; bit 4 and up are not stored, so a stray
   // one there cannot disturb anything
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         enable <= aei_pkg::ENABLE_RST;
      end else if (wr_en && hit_enable) begin
         enable <= wr_data[SW-1:0];
      end
   end

   // block-level alarm enable
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         block_en <= aei_pkg::BLOCK_RST;
      end else if (wr_en && hit_block) begin
         block_en <= wr_data[aei_pkg::BLOCK_ALARM_BIT];
      end
   end

   // framing check tolerance and window
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         tolerance <= aei_pkg::TOL_RST;
         window    <= aei_pkg::WIN_RST;
      end else if (wr_en && hit_cfg) begin
         tolerance <= wr_data[aei_pkg::TOL_LSB +: CW];
         window    <= wr_data[aei_pkg::WIN_LSB +: CW];
      end
   end

   // ------------------------------------------------------------------
   // read path, one cycle latency; unmapped addresses read zero
   // ------------------------------------------------------------------

   assign state_byte = {5'h00, oof_defect, ais_defect, yellow_alarm};

   // reserved upper bits always read as zero
   assign next_rd_data =
      hit_status ? zext4(status) :
      hit_enable ? zext4(enable) :
      hit_block  ? {7'h00, block_en} :
      hit_cfg    ? {window, tolerance} :
      hit_state  ? state_byte :
                   8'h00;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rd_data <= 8'h00;
      end else if (rd_en) begin
         rd_data <= next_rd_data;
      end else begin
         rd_data <= 8'h00;
      end
   end

   // ------------------------------------------------------------------
   // interrupt request
   // ------------------------------------------------------------------

   // registered from the current flags: one cycle behind them, which
   // keeps the pin glitch free at the cost of a cycle of latency
   assign next_irq = block_en &&
                     (|(status & enable));

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= next_irq;
      end
   end

endmodule

/* tb/aei_checker.sv */
`timescale 1ns/1ps
// port-level watcher for the alarm and error interrupt block
module aei_checker #(
   parameter int unsigned AIS_CYC = 8
) (
   input wire logic       mclk,                // system clock
   input wire logic       rst_n,               // synchronous reset
   input wire logic [3:0] addr,                // register address
   input wire logic [7:0] wr_data,             // write data
   input wire logic       wr_en,               // write strobe
   input wire logic       rd_en,               // read strobe
   input wire logic [7:0] rd_data,             // read data
   input wire logic       frame_sync_found,    // sync regained
   input wire logic       ais_cond,            // raw ais condition
   input wire logic       remote_alarm_cond,   // raw remote alarm
   input wire logic       line_code_violation, // violation pulse
   input wire logic       irq,                 // interrupt request
   input wire logic       oof_defect,          // out-of-frame state
   input wire logic       ais_defect,          // filtered ais
   input wire logic       yellow_alarm         // filtered yellow
);
   logic [3:0]  en_sh;   // mirror of the source enable register
   logic        blk_sh;  // mirror of the block enable
   logic [31:0] ais_run; // consecutive cycles with ais_cond high
   logic [2:0]  def_q;   // defect states one cycle back
   logic        quiet;   // no defect changed this cycle
   logic        idle;    // no register access
   logic        st_rd;   // status read
   assign quiet = (def_q == {oof_defect, ais_defect, yellow_alarm});
   assign idle  = !rd_en && !wr_en;
   assign st_rd = rd_en && (addr == aei_pkg::STATUS_OFS);
   // mirrors track bus writes so gating is judged from the ports alone
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         en_sh   <= 4'h0;
         blk_sh  <= 1'b0;
         ais_run <= 32'h0;
         def_q   <= 3'h0;
      end else begin
         if (wr_en && addr == aei_pkg::ENABLE_OFS) en_sh <= wr_data[3:0];
         if (wr_en && addr == aei_pkg::BLOCK_OFS) blk_sh <= wr_data[0];
         ais_run <= ais_cond ? ais_run + {31'h0, ~&ais_run} : 32'h0;
         def_q   <= {oof_defect, ais_defect, yellow_alarm};
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   a_upper_zero: assert property (st_rd |=> rd_data[7:4] == 4'h0)
      else $error("upper status bits not zero");
   a_block_gate: assert property (!blk_sh |=> !irq)
      else $error("irq while block enable clear");
   a_enable_gate: assert property (en_sh == 4'h0 |=> !irq)
      else $error("irq while all enables clear");
   a_lcv_irq: assert property (line_code_violation && !wr_en
      && en_sh[aei_pkg::LCV_BIT] && blk_sh |-> ##2 irq)
      else $error("violation did not raise irq");
   a_read_clears: assert property ((st_rd && !line_code_violation
      && quiet) ##1 quiet |-> ##1 !irq)
      else $error("irq stayed after status read");
   a_oof_flag: assert property (($changed(oof_defect) && idle)
      ##1 idle ##1 st_rd |=> rd_data[aei_pkg::OOF_BIT])
      else $error("frame-loss change flag missing");
   a_ais_flag: assert property (($changed(ais_defect) && idle)
      ##1 idle ##1 st_rd |=> rd_data[aei_pkg::AIS_BIT])
      else $error("ais change flag missing");
   a_yel_flag: assert property (($changed(yellow_alarm) && idle)
      ##1 idle ##1 st_rd |=> rd_data[aei_pkg::YEL_BIT])
      else $error("remote alarm change flag missing");
   a_yel_clear: assert property (yellow_alarm && !remote_alarm_cond
      |-> ##[1:2] !yellow_alarm)
      else $error("yellow alarm not cleared at once");
   a_ais_early: assert property ($rose(ais_defect)
      |-> ais_run >= AIS_CYC - 1)
      else $error("ais declared too early");
   a_oof_sync: assert property (oof_defect && frame_sync_found
      |=> !oof_defect)
      else $error("out-of-frame kept after sync");
endmodule
bind aei_top aei_checker #(.AIS_CYC(AIS_CYC)) i_aei_checker (
   .mclk, .rst_n, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
   .frame_sync_found, .ais_cond, .remote_alarm_cond,
   .line_code_violation, .irq, .oof_defect, .ais_defect, .yellow_alarm);

/* tb/aei_top_tb.sv */
`timescale 1ns/1ps
module aei_top_tb;
   localparam logic [3:0] ST = aei_pkg::STATUS_OFS;
   localparam logic [3:0] EN = aei_pkg::ENABLE_OFS;
   localparam logic [3:0] BL = aei_pkg::BLOCK_OFS;
   localparam logic [3:0] CF = aei_pkg::OOF_CFG_OFS;
   localparam logic [3:0] SS = aei_pkg::STATE_OFS;
   logic       mclk = 1'b0;
   logic       rst_n = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wr_data = 8'h00;
   logic       wr_en = 1'b0;
   logic       rd_en = 1'b0;
   logic [7:0] rd_data;
   logic       framing_bit_valid = 1'b0;
   logic       framing_bit_err = 1'b0;
   logic       frame_sync_found = 1'b0;
   logic       ais_cond = 1'b0;
   logic       remote_alarm_cond = 1'b0;
   logic       line_code_violation = 1'b0;
   logic       irq;
   logic       oof_defect;
   logic       ais_defect;
   logic       yellow_alarm;
   int         n_errors = 0;
   int         check_count = 0;
   int         cyc = 0;
   // persistence counts shortened so the run stays brief
   aei_top #(.AIS_CYC(8), .YEL_CYC(16)) i_aei_top (
      .mclk, .rst_n, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
      .framing_bit_valid, .framing_bit_err, .frame_sync_found, .ais_cond,
      .remote_alarm_cond, .line_code_violation, .irq, .oof_defect,
      .ais_defect, .yellow_alarm);
   always #10 mclk = ~mclk;
   task automatic report_and_stop();
      if (n_errors == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // hang guard: the whole sequence needs about 150 cycles
   always @(posedge mclk) begin
      cyc = cyc + 1;
      if (cyc == 3000) begin
         n_errors = n_errors + 1;
         report_and_stop();
      end
   end
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      check_count = check_count + 1;
      if (got !== exp) begin
         n_errors = n_errors + 1;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk8({7'h00, got}, {7'h00, exp});
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge mclk);
      wr_en <= 1'b0;
   endtask
   // read data is looked at only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge mclk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge mclk);
      rd_en <= 1'b0;
      #1 chk8(rd_data, exp);
   endtask
   task automatic lcv_pulse();
      @(posedge mclk);
      line_code_violation <= 1'b1;
      @(posedge mclk);
      line_code_violation <= 1'b0;
   endtask
   task automatic irq_after(input int n, input logic exp);
      repeat (n) @(posedge mclk);
      #1 chk1(irq, exp);
   endtask
   task automatic fb(input logic e);
      @(posedge mclk);
      framing_bit_valid <= 1'b1;
      framing_bit_err <= e;
   endtask
   task automatic fb_stop();
      @(posedge mclk);
      framing_bit_valid <= 1'b0;
      framing_bit_err <= 1'b0;
   endtask
   // one sync pulse, then wait for the out-of-frame state to drop
   task automatic resync();
      @(posedge mclk);
      frame_sync_found <= 1'b1;
      @(posedge mclk);
      frame_sync_found <= 1'b0;
      while (oof_defect) @(posedge mclk);
   endtask
   initial begin
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      rd(ST, 8'h00);
      rd(EN, 8'h00);
      rd(CF, 8'h42);
      wr(4'hF, 8'h5A);
      rd(4'hF, 8'h00);
      wr(EN, 8'hE7);
      rd(EN, 8'h07);
      wr(BL, 8'h01);
      lcv_pulse();
      irq_after(2, 1'b0);
      rd(ST, 8'h08);
      wr(EN, 8'h08);
      lcv_pulse();
      irq_after(2, 1'b1);
      rd(ST, 8'h08);
      irq_after(2, 1'b0);
      rd(ST, 8'h00);
      // violation in the very cycle of a status read must survive
      @(posedge mclk);
      addr <= ST;
      rd_en <= 1'b1;
      line_code_violation <= 1'b1;
      @(posedge mclk);
      rd_en <= 1'b0;
      line_code_violation <= 1'b0;
      rd(ST, 8'h08);
      wr(BL, 8'h00);
      lcv_pulse();
      irq_after(3, 1'b0);
      wr(BL, 8'h01);
      irq_after(2, 1'b1);
      wr(ST, 8'h08);
      rd(ST, 8'h00);
      // errors in separate windows, then a second one inside a window
      wr(EN, 8'h04);
      fb(1'b1);
      fb(1'b0);
      fb(1'b0);
      fb(1'b0);
      fb(1'b1);
      fb(1'b0);
      fb_stop();
      repeat (2) @(posedge mclk);
      #1 chk1(oof_defect, 1'b0);
      fb(1'b1);
      fb_stop();
      while (!oof_defect) @(posedge mclk);
      rd(ST, 8'h04);
      chk1(irq, 1'b1);
      rd(SS, 8'h04);
      resync();
      rd(ST, 8'h04);
      // a tolerance of one declares on the first wrong framing bit
      wr(CF, 8'h41);
      rd(CF, 8'h41);
      fb(1'b1);
      fb_stop();
      repeat (2) @(posedge mclk);
      #1 chk1(oof_defect, 1'b1);
      resync();
      rd(ST, 8'h04);
      wr(EN, 8'h02);
      @(posedge mclk);
      ais_cond <= 1'b1;
      while (!ais_defect) @(posedge mclk);
      rd(ST, 8'h02);
      chk1(irq, 1'b1);
      rd(SS, 8'h02);
      @(posedge mclk);
      ais_cond <= 1'b0;
      while (ais_defect) @(posedge mclk);
      rd(ST, 8'h02);
      wr(EN, 8'h01);
      @(posedge mclk);
      remote_alarm_cond <= 1'b1;
      while (!yellow_alarm) @(posedge mclk);
      rd(ST, 8'h01);
      chk1(irq, 1'b1);
      rd(SS, 8'h01);
      @(posedge mclk);
      remote_alarm_cond <= 1'b0;
      repeat (2) @(posedge mclk);
      #1 chk1(yellow_alarm, 1'b0);
      rd(ST, 8'h01);
      report_and_stop();
   end
endmodule
